// file: rtl/rscp_device.sv
// radio end of the serial configuration port plus recovered clock output
// assumes the host clocks the link; recovery logic gives its own clock
//
// What this block does
// - recovery disabled: recovered clock stays low
// - recovery enabled: clock low until start symbol
// - bit presented on clock rise, stable at fall
// - clock pulses until host clears recovery bit
// - host should clear recovery after each packet
// - data moves only while select is high
// - every eighth data bit of a write stores a byte
// - write bits captured on serial clock rise
// - read bits driven on serial clock rise
// - serial clock ignored while select is low
// - host drives writes, device drives reads
// - first select rise enters serial mode permanently
// - select low at power-on: pin control mode
// - first serial clock of a frame wakes the device from sleep
// - start symbol switches data output to recovered
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "rscp_regs.svh"

module rscp_device (
  input  wire logic              reset,
  rscp_if.device                 link,
  input  wire logic              recovery_clk,
  input  wire logic              slicer_data,
  input  wire logic              start_symbol_found,
  input  wire logic              recovered_data,
  output logic                   recovered_bit_clock,
  output logic                   receive_data_out,
  output logic                   serial_control_mode,
  output rscp_pkg::rscp_cfg_bank_t config_regs
);

  // ---------------------------------------------------------------
  // link side, clocked by the host serial clock; the mode latch by select
  // ---------------------------------------------------------------
  logic       frame_rst;
  logic       din;
  logic       hdr_done;
  logic [1:0] hdr_cnt;
  logic [1:0] hdr_sr;
  logic       rd_mode;
  logic [1:0] ptr;
  logic [2:0] bit_cnt;
  logic [6:0] wr_sr;
  logic       byte_commit;
  logic       frame_first;
  logic [7:0] byte_value;
  logic [2:0] rd_index;

  // the clock may stand still outside a frame, so the frame is ended
  // by select itself rather than by a clock edge
  assign frame_rst   = reset | ~link.config_select;
  assign din         = link.serial_config_data;
  assign byte_value  = {wr_sr, din};
  assign byte_commit = hdr_done & ~rd_mode & (bit_cnt == `RSCP_BIT_LAST);
  assign frame_first = ~hdr_done & (hdr_cnt == 2'h0);
  assign rd_index    = `RSCP_BIT_LAST - bit_cnt;

  // header then data bits, all sampled on the rising edge
  always_ff @(posedge link.serial_config_clock or posedge frame_rst) begin
    if (frame_rst) begin
      hdr_done <= 1'b0;
      hdr_cnt  <= 2'h0;
      hdr_sr   <= 2'h0;
      rd_mode  <= 1'b0;
      ptr      <= 2'h0;
      bit_cnt  <= 3'h0;
      wr_sr    <= 7'h00;
    end else if (!hdr_done) begin
      hdr_sr  <= {hdr_sr[0], din};
      hdr_cnt <= hdr_cnt + 2'h1;
      if (hdr_cnt == `RSCP_HDR_LAST) begin
        hdr_done <= 1'b1;
        rd_mode  <= hdr_sr[1];
        ptr      <= {hdr_sr[0], din};
      end
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      if (!rd_mode) begin
        wr_sr <= {wr_sr[5:0], din};
      end
      // consecutive bytes go to consecutive registers
      if (bit_cnt == `RSCP_BIT_LAST) begin
        ptr <= ptr + 2'h1;
      end
    end
  end

  // read data leaves on the rising edge so the host can take it at the fall
  always_ff @(posedge link.serial_config_clock or posedge frame_rst) begin
    if (frame_rst) begin
      link.dev_data_out <= 1'b0;
      link.dev_data_oe  <= 1'b0;
    end else if (hdr_done && rd_mode) begin
      link.dev_data_oe  <= 1'b1;
      link.dev_data_out <= config_regs[ptr][rd_index];
    end
  end

  // configuration bank survives frames, cleared only by power-on reset
  always_ff @(posedge link.serial_config_clock or posedge reset) begin
    if (reset) begin
      config_regs <= {4{`RSCP_CFG_RESET}};
    end else if (link.config_select) begin
      // wake happens on the first clock of the frame, since no edge
      // arrives with the select rise itself
      if (frame_first) begin
        config_regs[0][`RSCP_CONFIG_REGISTER_ZERO_SLEEP_BIT] <= 1'b0;
      end
      if (byte_commit) begin
        config_regs[ptr] <= byte_value;
      end
    end
  end

  // mode latch: only power-on reset returns it to pin control
  always_ff @(posedge link.config_select or posedge reset) begin
    if (reset) begin
      serial_control_mode <= 1'b0;
    end else begin
      serial_control_mode <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // receive side, clocked by the recovery clock
  // ---------------------------------------------------------------
  logic en_s1;
  logic en_s2;
  logic slice_s1;
  logic slice_s2;
  logic rx_active;

  always_ff @(posedge recovery_clk or posedge reset) begin
    if (reset) begin
      en_s1    <= 1'b0;
      en_s2    <= 1'b0;
      slice_s1 <= 1'b0;
      slice_s2 <= 1'b0;
    end else begin
      en_s1    <= config_regs[0][`RSCP_CONFIG_REGISTER_ZERO_RECOV_BIT];
      en_s2    <= en_s1;
      slice_s1 <= slicer_data;
      slice_s2 <= slice_s1;
    end
  end

  // once started the clock runs on until software drops the enable
  always_ff @(posedge recovery_clk or posedge reset) begin
    if (reset) begin
      rx_active <= 1'b0;
    end else if (!en_s2) begin
      rx_active <= 1'b0;
    end else if (start_symbol_found) begin
      rx_active <= 1'b1;
    end
  end

  always_ff @(posedge recovery_clk or posedge reset) begin
    if (reset) begin
      recovered_bit_clock <= 1'b0;
    end else if (rx_active && en_s2) begin
      recovered_bit_clock <= ~recovered_bit_clock;
    end else begin
      recovered_bit_clock <= 1'b0;
    end
  end

  // new bit only when the clock goes high, so it holds through the fall
  always_ff @(posedge recovery_clk or posedge reset) begin
    if (reset) begin
      receive_data_out <= 1'b0;
    end else if (rx_active && en_s2) begin
      if (!recovered_bit_clock) begin
        receive_data_out <= recovered_data;
      end
    end else begin
      receive_data_out <= slice_s2;
    end
  end

endmodule // rscp_device

// file: rtl/rscp_host.sv
// host end: turns command port orders into serial configuration frames
// assumes a 20 MHz clock; it makes the serial clock by division
`timescale 1ns/1ps
`include "rscp_regs.svh"

module rscp_host (
  input  wire logic        clk,
  input  wire logic        reset,
  rscp_if.host             link,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [31:0]      bus_rdata
);

  rscp_pkg::rscp_host_state_t state;
  logic [4:0]  tmr;
  logic [4:0]  bitno;
  logic [4:0]  nbits;
  logic        is_read;
  logic [18:0] tx_sr;
  logic [15:0] rx_sr;
  logic [15:0] wdata;
  logic        sin_s1;
  logic        sin_s2;
  logic        start;
  logic        tmr_end;
  logic [4:0]  next_bitno;

  assign start      = bus_wr & (bus_addr == `RSCP_H_CTRL) & (state == rscp_pkg::RSCP_IDLE);
  assign tmr_end    = (tmr == `RSCP_TMR_DONE);
  assign next_bitno = bitno + 5'h01;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sin_s1 <= 1'b1;
      sin_s2 <= 1'b1;
    end else begin
      sin_s1 <= link.serial_config_data;
      sin_s2 <= sin_s1;
    end
  end

  // command port; a control write while busy is dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdata     <= 16'h0000;
      bus_rdata <= 32'h0000_0000;
    end else begin
      if (bus_wr && bus_addr == `RSCP_H_WDATA) begin
        wdata <= bus_wdata[15:0];
      end
      if (bus_rd) begin
        case (bus_addr)
          `RSCP_H_WDATA:  bus_rdata <= {16'h0000, wdata};
          `RSCP_H_RDATA:  bus_rdata <= {16'h0000, rx_sr};
          `RSCP_H_STATUS: bus_rdata <= {31'h0000_0000, state != rscp_pkg::RSCP_IDLE};
          default:        bus_rdata <= 32'h0000_0000;
        endcase
      end else begin
        bus_rdata <= 32'h0000_0000;
      end
    end
  end

  // frame sequencer; clock held low before select rises
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state                    <= rscp_pkg::RSCP_IDLE;
      tmr                      <= 5'h00;
      bitno                    <= 5'h00;
      nbits                    <= 5'h00;
      is_read                  <= 1'b0;
      tx_sr                    <= 19'h00000;
      rx_sr                    <= 16'h0000;
      link.config_select       <= 1'b0;
      link.serial_config_clock <= 1'b0;
      link.host_data_out       <= 1'b0;
      link.host_data_oe        <= 1'b0;
    end else begin
      case (state)
        rscp_pkg::RSCP_IDLE: begin
          if (start) begin
            is_read <= bus_wdata[`RSCP_CTRL_RW];
            nbits   <= bus_wdata[`RSCP_CTRL_TWO] ? `RSCP_BITS_TWO : `RSCP_BITS_ONE;
            tx_sr   <= {bus_wdata[`RSCP_CTRL_RW],
                        bus_wdata[`RSCP_CTRL_ADDR_HI:`RSCP_CTRL_ADDR_LO], wdata};
            tmr     <= bus_wdata[`RSCP_CTRL_SLOW] ? `RSCP_CFGSU_SLEEP_CYC : `RSCP_CFGSU_CYC;
            bitno   <= 5'h00;
            // a one-byte read must not show bits of an earlier frame
            rx_sr   <= 16'h0000;
            state   <= rscp_pkg::RSCP_SETUP;
            link.config_select <= 1'b1;
          end
        end
        rscp_pkg::RSCP_SETUP: begin
          link.host_data_oe  <= 1'b1;
          link.host_data_out <= tx_sr[18];
          tmr                <= tmr - 5'h01;
          if (tmr_end) begin
            tx_sr <= {tx_sr[17:0], 1'b0};
            tmr   <= `RSCP_SCC_HALF_CYC;
            state <= rscp_pkg::RSCP_SHIFT;
            link.serial_config_clock <= 1'b1;
          end
        end
        rscp_pkg::RSCP_SHIFT: begin
          tmr <= tmr - 5'h01;
          if (tmr_end && link.serial_config_clock) begin
            link.serial_config_clock <= 1'b0;
            tmr   <= `RSCP_SCC_HALF_CYC;
            bitno <= next_bitno;
            if (is_read && bitno >= `RSCP_HDR_BITS) begin
              rx_sr <= {rx_sr[14:0], sin_s2};
            end
            if (next_bitno == nbits) begin
              link.config_select <= 1'b0;
              link.host_data_oe  <= 1'b0;
              tmr   <= `RSCP_CFGLO_CYC;
              state <= rscp_pkg::RSCP_GAP;
            end else if (is_read && next_bitno >= `RSCP_HDR_BITS) begin
              link.host_data_oe <= 1'b0;
            end else begin
              link.host_data_out <= tx_sr[18];
              tx_sr <= {tx_sr[17:0], 1'b0};
            end
          end else if (tmr_end) begin
            link.serial_config_clock <= 1'b1;
            tmr <= `RSCP_SCC_HALF_CYC;
          end
        end
        rscp_pkg::RSCP_GAP: begin
          tmr <= tmr - 5'h01;
          if (tmr_end) begin
            state <= rscp_pkg::RSCP_IDLE;
          end
        end
        default: state <= rscp_pkg::RSCP_IDLE;
      endcase
    end
  end

endmodule // rscp_host

// file: rtl/rscp_if.sv
// three-wire configuration link between host and radio
// assumes the host makes select and clock; data line resolved from enables
`timescale 1ns/1ps

interface rscp_if;
  logic config_select;
  logic serial_config_clock;
  logic host_data_out;
  logic host_data_oe;
  logic dev_data_out;
  logic dev_data_oe;
  logic serial_config_data;

  // idle line floats high through a pull-up
  assign serial_config_data = host_data_oe ? host_data_out :
                              dev_data_oe  ? dev_data_out  : 1'b1;

  modport device (
    input  config_select,
    input  serial_config_clock,
    input  serial_config_data,
    output dev_data_out,
    output dev_data_oe
  );

  modport host (
    output config_select,
    output serial_config_clock,
    output host_data_out,
    output host_data_oe,
    input  serial_config_data
  );
endinterface

// file: rtl/rscp_pkg.sv
// types shared by the radio serial configuration port ends
// assumes rscp_regs.svh holds the numeric constants
package rscp_pkg;

  typedef logic [3:0][7:0] rscp_cfg_bank_t;

  typedef enum logic [2:0] {
    RSCP_IDLE  = 3'h0,
    RSCP_SETUP = 3'h1,
    RSCP_SHIFT = 3'h2,
    RSCP_GAP   = 3'h3
  } rscp_host_state_t;

endpackage

// file: rtl/rscp_regs.svh
// constants for the radio serial configuration port, both ends
// assumes the host clock runs at 20 MHz; counts derive from it
`ifndef RSCP_REGS_SVH
`define RSCP_REGS_SVH

`define RSCP_CLK_NS          50
`define RSCP_CYC(ns)         (((ns) + `RSCP_CLK_NS - 1) / `RSCP_CLK_NS)

// serial clock half period, chosen above the 90 ns high and low minimum
`define RSCP_SCC_HALF_NS     150
`define RSCP_CFGSU_NS        90
`define RSCP_CFGSU_SLEEP_NS  1000
`define RSCP_CFGLO_NS        90
`define RSCP_SCC_HALF_CYC    5'(`RSCP_CYC(`RSCP_SCC_HALF_NS))
`define RSCP_CFGSU_CYC       5'(`RSCP_CYC(`RSCP_CFGSU_NS))
`define RSCP_CFGSU_SLEEP_CYC 5'(`RSCP_CYC(`RSCP_CFGSU_SLEEP_NS))
`define RSCP_CFGLO_CYC       5'(`RSCP_CYC(`RSCP_CFGLO_NS))
`define RSCP_TMR_DONE        5'h01

// frame layout: read/write flag, two address bits, then bytes msb first
`define RSCP_HDR_LAST        2'h2
`define RSCP_BIT_LAST        3'h7
`define RSCP_HDR_BITS        5'h03
`define RSCP_BITS_ONE        5'h0b
`define RSCP_BITS_TWO        5'h13

// fields of config register zero
`define RSCP_CONFIG_REGISTER_ZERO_RECOV_BIT  0
`define RSCP_CONFIG_REGISTER_ZERO_SLEEP_BIT  7
`define RSCP_CFG_RESET       8'h00

// host command port map
`define RSCP_H_CTRL          4'h0
`define RSCP_H_WDATA         4'h4
`define RSCP_H_RDATA         4'h8
`define RSCP_H_STATUS        4'hc
`define RSCP_CTRL_RW         0
`define RSCP_CTRL_ADDR_LO    1
`define RSCP_CTRL_ADDR_HI    2
`define RSCP_CTRL_TWO        3
`define RSCP_CTRL_SLOW       4

`endif

// file: tb/radio_serial_config_port_test.sv
// self-checking bench: host and radio ends joined by the link interface
// assumes a 20 MHz host clock and an unrelated 15 ns recovery clock
`timescale 1ns/1ps
`include "rscp_regs.svh"

module radio_serial_config_port_test;
  logic                     clk;
  logic                     rclk;
  logic                     reset;
  logic [3:0]               bus_addr;
  logic [31:0]              bus_wdata;
  logic                     bus_wr;
  logic                     bus_rd;
  logic [31:0]              bus_rdata;
  logic                     slicer_data;
  logic                     start_sym;
  logic                     rec_data;
  logic                     rbc;
  logic                     rx_out;
  logic                     ser_mode;
  rscp_pkg::rscp_cfg_bank_t regs;
  rscp_pkg::rscp_cfg_bank_t model;
  int                       miscompares;
  int                       num_checks;
  int                       rises;
  int                       seed;
  logic                     exp_bit;
  logic                     watch;
  logic [31:0]              rd;
  logic [15:0]              w;
  logic [1:0]               a;

  rscp_if link ();
  rscp_host i_rscp_host (.clk(clk), .reset(reset), .link(link.host), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  rscp_device i_rscp_device (.reset(reset), .link(link.device), .recovery_clk(rclk),
    .slicer_data(slicer_data), .start_symbol_found(start_sym), .recovered_data(rec_data),
    .recovered_bit_clock(rbc), .receive_data_out(rx_out), .serial_control_mode(ser_mode),
    .config_regs(regs));
  rscp_assertions i_rscp_assertions (.clk(clk), .reset(reset),
    .config_select(link.config_select), .serial_config_clock(link.serial_config_clock),
    .host_data_out(link.host_data_out), .host_data_oe(link.host_data_oe),
    .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rclk = 1'b0;
    #3.7;
    forever #7.5 rclk = ~rclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // any frame wakes the radio first; a write to register zero then wins
  function automatic rscp_pkg::rscp_cfg_bank_t next_bank(rscp_pkg::rscp_cfg_bank_t b,
      logic rw, logic [1:0] ad, logic two, logic [15:0] d);
    b[0][`RSCP_CONFIG_REGISTER_ZERO_SLEEP_BIT] = 1'b0;
    if (!rw) begin
      b[ad] = d[15:8];
      if (two) b[ad + 2'h1] = d[7:0];
    end
    return b;
  endfunction

  function automatic logic [31:0] expect_read(rscp_pkg::rscp_cfg_bank_t b, logic [1:0] ad,
      logic two);
    return two ? {16'h0, b[ad], b[ad + 2'h1]} : {24'h0, b[ad]};
  endfunction

  task automatic bus_write(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= ad;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] ad, output logic [31:0] d);
    @(posedge clk);
    bus_addr <= ad;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  // long setup only while the model has the radio asleep, so both setups run
  task automatic frame(input logic rw, input logic [1:0] ad, input logic two,
      input logic [15:0] d);
    bus_write(`RSCP_H_WDATA, {16'h0, d});
    bus_write(`RSCP_H_CTRL, {27'h0, model[0][`RSCP_CONFIG_REGISTER_ZERO_SLEEP_BIT], two, ad, rw});
    repeat (2) @(posedge clk);
    rd = 32'h1;
    for (int i = 0; i < 200 && rd[0]; i++) bus_read(`RSCP_H_STATUS, rd);
    check("busy", rd, 32'h0);
    model = next_bank(model, rw, ad, two, d);
  endtask

  task automatic rx_pulse();
    rises = 0;
    slicer_data <= 1'($random(seed));
    @(negedge rclk);
    start_sym <= 1'b1;
    @(negedge rclk);
    start_sym <= 1'b0;
    repeat (40) @(negedge rclk);
  endtask

  always @(negedge rclk) rec_data <= 1'($random(seed));
  always @(posedge rbc) begin
    rises++;
    exp_bit = rec_data;
  end
  always @(negedge rbc) if (watch) check("rx bit", {31'h0, rx_out}, {31'h0, exp_bit});

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial begin
    seed = 32'he924;
    reset = 1'b1;
    bus_addr = 4'h0;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    slicer_data = 1'b0;
    start_sym = 1'b0;
    rec_data = 1'b0;
    watch = 1'b0;
    model = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("serial mode", {31'h0, ser_mode}, 32'h0);
    check("bank", regs, model);
    bus_read(4'h2, rd);
    check("unmapped", rd, 32'h0);
    frame(1'b0, 2'h0, 1'b0, 16'h8080);
    check("serial mode", {31'h0, ser_mode}, 32'h1);
    bus_read(`RSCP_H_WDATA, rd);
    check("wdata", rd, 32'h0000_8080);
    check("bank", regs, model);
    for (int n = 0; n < 10; n++) begin
      w = 16'($random(seed));
      a = 2'($random(seed));
      frame(1'b0, a, 1'b1, w);
      check("bank", regs, model);
      a = 2'($random(seed));
      frame(1'b1, a, n[0], 16'h0);
      bus_read(`RSCP_H_RDATA, rd);
      check("read", rd, expect_read(model, a, n[0]));
    end
    frame(1'b0, 2'h0, 1'b0, 16'h0000);
    rx_pulse();
    check("clock off", rises, 0);
    check("slicer", {31'h0, rx_out}, {31'h0, slicer_data});
    frame(1'b0, 2'h0, 1'b0, 16'h0101);
    repeat (20) @(negedge rclk);
    check("clock wait", rises, 0);
    watch = 1'b1;
    rx_pulse();
    check("clock run", 32'(rises >= 15), 32'h1);
    // the forced low on disable carries no data bit, so bit checks stop first
    watch = 1'b0;
    frame(1'b0, 2'h0, 1'b0, 16'h0000);
    rises = 0;
    repeat (20) @(negedge rclk);
    check("clock stop", rises, 0);
    check("slicer", {31'h0, rx_out}, {31'h0, slicer_data});
    summarize();
  end
endmodule // radio_serial_config_port_test

// file: tb/rscp_assertions.sv
// checker for the three-wire configuration link between host and radio
// assumes it sits beside rscp_if in the bench, sampled in the host clock domain
`timescale 1ns/1ps
`include "rscp_regs.svh"

module rscp_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic config_select,
  input wire logic serial_config_clock,
  input wire logic host_data_out,
  input wire logic host_data_oe,
  input wire logic dev_data_out,
  input wire logic dev_data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  logic       sck_q;
  logic [4:0] rises;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= serial_config_clock;
    end
  end

  // serial clock rises within the current frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rises <= 5'h00;
    end else if (!config_select) begin
      rises <= 5'h00;
    end else if (serial_config_clock && !sck_q) begin
      rises <= rises + 5'h01;
    end
  end

  sequence s_high_phase;
    serial_config_clock [*3] ##1 !serial_config_clock;
  endsequence
  sequence s_host_hold;
    $stable(host_data_out) [*2];
  endsequence

  a_release_idle: assert property (!config_select |-> !dev_data_oe && !host_data_oe)
    else $error("data line driven outside a frame");
  a_one_driver: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data line");
  a_sck_idle: assert property (!config_select |-> !serial_config_clock)
    else $error("serial clock active without select");
  a_select_setup: assert property ($rose(config_select) |-> !serial_config_clock ##1 !serial_config_clock)
    else $error("serial clock high too soon after select");
  a_sck_high: assert property ($rose(serial_config_clock) |-> s_high_phase)
    else $error("serial clock high phase wrong");
  a_sck_low: assert property ($fell(serial_config_clock) |-> !serial_config_clock [*3])
    else $error("serial clock low phase short");
  a_host_hold: assert property ($rose(serial_config_clock) && host_data_oe |=> s_host_hold)
    else $error("write bit not held after rise");
  a_dev_on_rise: assert property ($rose(dev_data_oe) |-> serial_config_clock)
    else $error("device drive began off a rise");
  a_dev_stable: assert property (dev_data_oe && $past(dev_data_oe) && !serial_config_clock
    |-> $stable(dev_data_out))
    else $error("read bit moved while clock low");
  a_frame_bits: assert property ($fell(config_select)
    |-> rises == `RSCP_BITS_ONE || rises == `RSCP_BITS_TWO)
    else $error("frame not whole bytes");
endmodule // rscp_assertions
